// ### include/mds_pkg.sv
package mds_pkg;

    // =====================================================
    // clock and timing
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned ROT_STEP_MS     = 250;
    localparam int unsigned ROT_CYCLES      = CLK_HZ / 1000 * ROT_STEP_MS;
    localparam int unsigned CONF_TIME_MS    = 10;
    localparam int unsigned CONF_CYCLES     = CLK_HZ / 1000 * CONF_TIME_MS;
    localparam int unsigned SUBTEST_TIME_MS = 100;
    localparam int unsigned SUBTEST_CYCLES  = CLK_HZ / 1000 * SUBTEST_TIME_MS;
    localparam int unsigned TMR_W           = 24;

    // =====================================================
    // register map (byte addresses)
    localparam int unsigned ADDR_W          = 12;
    localparam logic [11:0] OFS_CTRL        = 12'h000;
    localparam logic [11:0] OFS_STATUS      = 12'h004;
    localparam logic [11:0] OFS_INT_STATUS  = 12'h008;
    localparam logic [11:0] OFS_INT_MASK    = 12'h00C;
    localparam logic [11:0] OFS_COUNTS      = 12'h010;
    localparam int unsigned CTRL_INIT_BIT   = 0;
    localparam int unsigned CTRL_TXEN_BIT   = 1;
    localparam logic [1:0]  CTRL_RESET      = 2'h2;

    // interrupt status / mask bit positions
    localparam int unsigned INT_W           = 5;
    localparam int unsigned INT_CONF_FAULT  = 0;
    localparam int unsigned INT_DIAG_FAULT  = 1;
    localparam int unsigned INT_TX_ERR      = 2;
    localparam int unsigned INT_RX_ERR      = 3;
    localparam int unsigned INT_MODE_CHG    = 4;
    localparam logic [4:0]  INT_MASK_RESET  = 5'h00;

    // =====================================================
    // modes and led codes
    typedef enum logic [4:0] {
        MDS_CONF       = 5'h01,
        MDS_HALT       = 5'h02,
        MDS_RUN        = 5'h04,
        MDS_STANDALONE = 5'h08,
        MDS_HOSTBUS    = 5'h10
    } mds_mode_e;

    localparam logic [1:0] LED_CODE_CONF    = 2'h1;
    localparam logic [1:0] LED_CODE_STAND   = 2'h2;
    localparam logic [1:0] LED_CODE_HOSTBUS = 2'h3;
    localparam logic [1:0] ROT_SEED         = 2'h1;
    localparam logic [2:0] SUBTEST_FIRST    = 3'h1;
    localparam logic [2:0] SUBTEST_EXT      = 3'h7;
    localparam logic [3:0] FRAMES_TO_PASS   = 4'hA;
    // maintenance frame header: value is arbitrary
    localparam logic [7:0] X25_MAINT_HEADER = 8'h5A;

    typedef struct packed {
        logic [1:0] top;
        logic [2:0] mid;
        logic [2:0] low;
    } mds_led_s;

endpackage

// ### verilog/mds_top.sv
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module mds_top #(
    parameter int unsigned ROT_CYCLES     = mds_pkg::ROT_CYCLES,
    parameter int unsigned CONF_CYCLES    = mds_pkg::CONF_CYCLES,
    parameter int unsigned SUBTEST_CYCLES = mds_pkg::SUBTEST_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        dev_init,
    input  wire logic        bus_init,
    input  wire logic        run_test_switch,
    input  wire logic        loopback_present,
    input  wire logic [3:0]  maintenance_switch_pack,
    input  wire logic        selftest_fault,
    input  wire logic [2:0]  selftest_code,
    input  wire logic        diag_fault,
    input  wire logic [2:0]  diag_code,
    input  wire logic        frame_ok,
    input  wire logic        tx_error,
    input  wire logic        rx_error,
    output logic      [7:0]  led,
    output logic             control_code_run,
    output logic             tx_enable,
    output logic             diag_active,
    output logic             hostbus_active,
    output logic      [2:0]  subtest,
    output logic             x25_maint_tx,
    output logic      [7:0]  x25_maint_header,
    output logic             irq
);

    // =====================================================
    // declarations
    mds_pkg::mds_mode_e       mode;
    mds_pkg::mds_mode_e       next_mode;
    mds_pkg::mds_led_s        next_led;
    logic [mds_pkg::TMR_W-1:0] rot_tmr;
    logic [mds_pkg::TMR_W-1:0] phase_tmr;
    logic [1:0]               rot_pat;
    logic [2:0]               tx_cnt;
    logic [2:0]               rx_cnt;
    logic [2:0]               err_code;
    logic                     err_latched;
    logic [3:0]               frame_cnt;
    logic [1:0]               ctrl;
    logic                     soft_init;
    logic [mds_pkg::INT_W-1:0] int_status;
    logic [mds_pkg::INT_W-1:0] int_mask;
    logic [mds_pkg::INT_W-1:0] int_event;
    logic                     any_init;
    logic                     rot_step;
    logic                     phase_done;
    logic                     continuous;
    logic                     wr_acc;
    logic                     setup;
    logic                     addr_ok;
    logic [31:0]              next_rdata;

    assign any_init   = dev_init | bus_init | soft_init;
    assign rot_step   = (rot_tmr == mds_pkg::TMR_W'(ROT_CYCLES - 1));
    assign continuous = maintenance_switch_pack[0];
    assign setup      = psel & ~penable;
    assign wr_acc     = psel & penable & pready & pwrite;

    // =====================================================
    // mode sequencing
    always_comb begin
        next_mode = mode;
        case (mode)
            mds_pkg::MDS_CONF: begin
                if (selftest_fault) begin
                    next_mode = mds_pkg::MDS_HALT;
                end else if (phase_done) begin
                    next_mode = run_test_switch ? mds_pkg::MDS_STANDALONE
                                                : mds_pkg::MDS_RUN;
                end
            end
            mds_pkg::MDS_HALT: begin
                next_mode = mds_pkg::MDS_HALT;
            end
            mds_pkg::MDS_RUN, mds_pkg::MDS_HOSTBUS: begin
                if (run_test_switch) begin
                    next_mode = mds_pkg::MDS_STANDALONE;
                end
            end
            mds_pkg::MDS_STANDALONE: begin
                // leaving test goes through the confidence test, never straight to control code
                if (!run_test_switch) begin
                    next_mode = mds_pkg::MDS_CONF;
                end
            end
            default: begin
                next_mode = mds_pkg::MDS_CONF;
            end
        endcase
        if (any_init) begin
            if (loopback_present && !run_test_switch) begin
                next_mode = mds_pkg::MDS_HOSTBUS;
            end else begin
                next_mode = mds_pkg::MDS_CONF;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= mds_pkg::MDS_CONF;
        end else begin
            mode <= next_mode;
        end
    end

    // =====================================================
    // phase timer: confidence test length, subtest dwell
    assign phase_done = (phase_tmr == mds_pkg::TMR_W'(CONF_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_tmr <= '0;
        end else if (any_init || next_mode != mode) begin
            phase_tmr <= '0;
        end else if (mode == mds_pkg::MDS_CONF) begin
            phase_tmr <= phase_tmr + 1'b1;
        end else if (mode == mds_pkg::MDS_STANDALONE) begin
            if (phase_tmr == mds_pkg::TMR_W'(SUBTEST_CYCLES - 1)) begin
                phase_tmr <= '0;
            end else begin
                phase_tmr <= phase_tmr + 1'b1;
            end
        end
    end

    // =====================================================
    // subtest selection and error handling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            subtest <= '0;
        end else if (mode != mds_pkg::MDS_STANDALONE) begin
            subtest <= (next_mode == mds_pkg::MDS_STANDALONE) ? mds_pkg::SUBTEST_FIRST : 3'h0;
        end else if (continuous) begin
            subtest <= maintenance_switch_pack[3:1];
        end else if (err_latched && subtest != mds_pkg::SUBTEST_EXT) begin
            subtest <= subtest;                                       // loops on the failing test
        end else if (phase_tmr == mds_pkg::TMR_W'(SUBTEST_CYCLES - 1)) begin
            subtest <= (subtest == mds_pkg::SUBTEST_EXT) ? mds_pkg::SUBTEST_FIRST : subtest + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_latched <= 1'b0;
            err_code    <= '0;
            frame_cnt   <= '0;
        end else if (any_init || (next_mode != mode && next_mode != mds_pkg::MDS_HALT)) begin
            err_latched <= 1'b0;
            err_code    <= '0;
            frame_cnt   <= '0;
        end else if (mode == mds_pkg::MDS_CONF && selftest_fault) begin
            err_latched <= 1'b1;
            err_code    <= selftest_code;
        end else if (mode == mds_pkg::MDS_STANDALONE) begin
            if (diag_fault) begin
                err_latched <= 1'b1;
                err_code    <= diag_code;
                frame_cnt   <= '0;
            end else if (err_latched && subtest == mds_pkg::SUBTEST_EXT && frame_ok) begin
                // external test keeps going until enough clean frames
                if (frame_cnt == mds_pkg::FRAMES_TO_PASS - 4'h1) begin
                    err_latched <= 1'b0;
                    err_code    <= '0;
                    frame_cnt   <= '0;
                end else begin
                    frame_cnt <= frame_cnt + 4'h1;
                end
            end
        end
    end

    // =====================================================
    // run mode activity and error counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rot_tmr <= '0;
            rot_pat <= mds_pkg::ROT_SEED;
        end else if (mode != mds_pkg::MDS_RUN) begin
            rot_tmr <= '0;
            rot_pat <= mds_pkg::ROT_SEED;
        end else if (rot_step) begin
            rot_tmr <= '0;
            rot_pat <= {rot_pat[0], rot_pat[1]};
        end else begin
            rot_tmr <= rot_tmr + 1'b1;
        end
    end

    // 3-bit counters wrap by width, so eight errors read as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cnt <= '0;
            rx_cnt <= '0;
        end else if (any_init) begin
            tx_cnt <= '0;
            rx_cnt <= '0;
        end else if (mode == mds_pkg::MDS_RUN) begin
            if (tx_error) begin
                tx_cnt <= tx_cnt + 3'h1;
            end
            if (rx_error) begin
                rx_cnt <= rx_cnt + 3'h1;
            end
        end
    end

    // =====================================================
    // led display
    always_comb begin
        next_led = '0;
        case (mode)
            mds_pkg::MDS_RUN: begin
                next_led.top = rot_pat;
                next_led.mid = tx_cnt;
                next_led.low = rx_cnt;
            end
            mds_pkg::MDS_CONF, mds_pkg::MDS_HALT: begin
                next_led.top = mds_pkg::LED_CODE_CONF;
                next_led.low = err_code;
            end
            mds_pkg::MDS_STANDALONE: begin
                next_led.top = mds_pkg::LED_CODE_STAND;
                next_led.mid = subtest;
                next_led.low = err_code;
            end
            mds_pkg::MDS_HOSTBUS: begin
                next_led.top = mds_pkg::LED_CODE_HOSTBUS;
            end
            default: begin
                next_led = '0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led <= '0;
        end else begin
            led <= next_led;
        end
    end

    // =====================================================
    // control outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_code_run <= 1'b0;
            tx_enable        <= 1'b0;
            diag_active      <= 1'b0;
            hostbus_active   <= 1'b0;
            x25_maint_tx     <= 1'b0;
            x25_maint_header <= '0;
        end else begin
            control_code_run <= (next_mode == mds_pkg::MDS_RUN);
            diag_active      <= (next_mode == mds_pkg::MDS_STANDALONE);
            hostbus_active   <= (next_mode == mds_pkg::MDS_HOSTBUS);
            // halt forces transmit off whatever software asked for
            tx_enable        <= ctrl[mds_pkg::CTRL_TXEN_BIT] &&
                                (next_mode != mds_pkg::MDS_HALT);
            x25_maint_tx     <= (mode == mds_pkg::MDS_STANDALONE) &&
                                (subtest == mds_pkg::SUBTEST_EXT);
            x25_maint_header <= mds_pkg::X25_MAINT_HEADER;
        end
    end

    // =====================================================
    // interrupts: sticky, write one to clear, set wins
    always_comb begin
        int_event = '0;
        int_event[mds_pkg::INT_CONF_FAULT] = (mode == mds_pkg::MDS_CONF) && selftest_fault;
        int_event[mds_pkg::INT_DIAG_FAULT] = (mode == mds_pkg::MDS_STANDALONE) && diag_fault;
        int_event[mds_pkg::INT_TX_ERR]     = (mode == mds_pkg::MDS_RUN) && tx_error;
        int_event[mds_pkg::INT_RX_ERR]     = (mode == mds_pkg::MDS_RUN) && rx_error;
        int_event[mds_pkg::INT_MODE_CHG]   = (next_mode != mode);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= '0;
        end else if (wr_acc && pstrb[0] && paddr == mds_pkg::OFS_INT_STATUS) begin
            int_status <= (int_status & ~pwdata[mds_pkg::INT_W-1:0]) | int_event;
        end else begin
            int_status <= int_status | int_event;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status & int_mask);
        end
    end

    // =====================================================
    // apb slave: zero wait states, registered answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl      <= mds_pkg::CTRL_RESET;
            int_mask  <= mds_pkg::INT_MASK_RESET;
            soft_init <= 1'b0;
        end else begin
            soft_init <= 1'b0;
            if (wr_acc && pstrb[0]) begin
                case (paddr)
                    mds_pkg::OFS_CTRL: begin
                        ctrl      <= pwdata[1:0];
                        soft_init <= pwdata[mds_pkg::CTRL_INIT_BIT];
                    end
                    mds_pkg::OFS_INT_MASK: begin
                        int_mask <= pwdata[mds_pkg::INT_W-1:0];
                    end
                    default: begin
                        int_mask <= int_mask;
                    end
                endcase
            end
        end
    end

    always_comb begin
        next_rdata = '0;
        addr_ok    = 1'b1;
        case (paddr)
            mds_pkg::OFS_CTRL:       next_rdata = {30'h0, ctrl[1], 1'b0};
            mds_pkg::OFS_STATUS:     next_rdata = {11'h0, subtest, 1'b0, err_latched, led, 3'h0, mode};
            mds_pkg::OFS_INT_STATUS: next_rdata = {27'h0, int_status};
            mds_pkg::OFS_INT_MASK:   next_rdata = {27'h0, int_mask};
            mds_pkg::OFS_COUNTS:     next_rdata = {25'h0, tx_cnt, 1'b0, rx_cnt};
            default:                 addr_ok    = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~addr_ok;
            if (setup && !pwrite) begin
                prdata <= next_rdata;
            end
        end
    end

endmodule

// ### tb/mds_props.sv
`timescale 1ns/100ps
// ==========================================
// mode and led checker
module mds_props #(
    parameter int unsigned ROT_CYCLES = 8
) (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       dev_init,
    input wire logic       bus_init,
    input wire logic       run_test_switch,
    input wire logic       loopback_present,
    input wire logic       selftest_fault,
    input wire logic [7:0] led,
    input wire logic       control_code_run,
    input wire logic       tx_enable,
    input wire logic       diag_active,
    input wire logic       hostbus_active,
    input wire logic [2:0] subtest
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic        init;
    int unsigned still_cnt;
    assign init = dev_init | bus_init;

    // counts cycles the run indicator sits still
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            still_cnt <= 0;
        end else if (control_code_run && $stable(led[7:6])) begin
            still_cnt <= still_cnt + 1;
        end else begin
            still_cnt <= 0;
        end
    end

    a_conf_first: assert property (dev_init && !loopback_present |=> !control_code_run [*8])
        else $error("control code ran during confidence test");
    a_fault_halts: assert property (selftest_fault && !init && !control_code_run && !diag_active
        && !hostbus_active |=> !tx_enable && !control_code_run)
        else $error("confidence fault did not halt");
    a_never_both: assert property (!(control_code_run && (diag_active || hostbus_active)))
        else $error("diagnostic and control code together");
    a_switch_starts: assert property (control_code_run && run_test_switch && !init |=> diag_active)
        else $error("test switch did not start diagnostic");
    a_hostbus_entry: assert property ($rose(hostbus_active) |->
        $past(loopback_present) && !$past(run_test_switch))
        else $error("host-bus diagnostic entered wrongly");
    a_host_override: assert property (hostbus_active && run_test_switch && !init |=> diag_active)
        else $error("test switch did not override host-bus diagnostic");
    a_run_rotates: assert property (control_code_run && $past(control_code_run) |->
        (led[7:6] == 2'h1 || led[7:6] == 2'h2) && still_cnt < ROT_CYCLES + 3)
        else $error("run indicator not rotating");
    a_tx_wraps: assert property (control_code_run && $past(control_code_run, 3) && $changed(led[5:3])
        |-> led[5:3] == 3'($past(led[5:3]) + 3'h1))
        else $error("transmit count stepped wrongly");
    a_rx_wraps: assert property (control_code_run && $past(control_code_run, 3) && $changed(led[2:0])
        |-> led[2:0] == 3'($past(led[2:0]) + 3'h1))
        else $error("receive count stepped wrongly");
    a_stand_code: assert property (diag_active && $past(diag_active) |-> led[7:6] == 2'h2
        && (led[5:3] == subtest || led[5:3] == $past(subtest)))
        else $error("standalone display wrong");
    a_host_code: assert property (hostbus_active && $past(hostbus_active) |-> led[7:6] == 2'h3)
        else $error("host-bus display wrong");

    c_halt: cover property ($fell(tx_enable));
    c_host: cover property ($rose(hostbus_active));
    c_wrap: cover property (control_code_run && led[5:3] == 3'h0 && $past(led[5:3]) == 3'h7);
endmodule

bind mds_top mds_props #(.ROT_CYCLES(ROT_CYCLES)) u_props (
    .pclk(pclk), .presetn(presetn), .dev_init(dev_init), .bus_init(bus_init),
    .run_test_switch(run_test_switch), .loopback_present(loopback_present),
    .selftest_fault(selftest_fault), .led(led), .control_code_run(control_code_run),
    .tx_enable(tx_enable), .diag_active(diag_active), .hostbus_active(hostbus_active),
    .subtest(subtest)
);

// ### tb/mds_partner.sv
`timescale 1ns/100ps
// ==========================================
// switches and loopback connector
module mds_partner (
    input  wire logic       set_test,
    input  wire logic       set_loopback,
    input  wire logic [3:0] set_pack,
    output logic            run_test_switch,
    output logic            loopback_present,
    output logic      [3:0] maintenance_switch_pack
);
    // mechanical contacts: no bounce modelled, levels only
    assign run_test_switch         = set_test;
    assign loopback_present        = set_loopback;
    assign maintenance_switch_pack = set_pack;
endmodule

// ### tb/test_microdiagnostic_mode_and_led_status.sv
`timescale 1ns/100ps
module test_microdiagnostic_mode_and_led_status;
    // ==========================================
    // signals
    localparam int unsigned ROT = 8;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, ccr, tx_enable, diag_active, hostbus_active, x25_maint_tx, irq;
    logic        dev_init = 1'b0, bus_init = 1'b0, selftest_fault = 1'b0, diag_fault = 1'b0;
    logic        tx_error = 1'b0, rx_error = 1'b0, set_test = 1'b0, set_loopback = 1'b0;
    logic [2:0]  selftest_code = 3'h0, diag_code = 3'h0, subtest;
    logic [3:0]  set_pack = 4'h0, pack;
    logic        rts, lbp;
    logic [7:0]  led, hdr;
    int          err_count = 0, tests_run = 0, cyc = 0;

    always #10 pclk = ~pclk;

    mds_partner u_partner (.set_test(set_test), .set_loopback(set_loopback), .set_pack(set_pack),
        .run_test_switch(rts), .loopback_present(lbp), .maintenance_switch_pack(pack));

    mds_top #(.ROT_CYCLES(ROT), .CONF_CYCLES(16), .SUBTEST_CYCLES(32)) DUT (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dev_init(dev_init), .bus_init(bus_init), .run_test_switch(rts),
        .loopback_present(lbp), .maintenance_switch_pack(pack), .selftest_fault(selftest_fault),
        .selftest_code(selftest_code), .diag_fault(diag_fault), .diag_code(diag_code),
        .frame_ok(1'b0), .tx_error(tx_error), .rx_error(rx_error), .led(led),
        .control_code_run(ccr), .tx_enable(tx_enable), .diag_active(diag_active),
        .hostbus_active(hostbus_active), .subtest(subtest), .x25_maint_tx(x25_maint_tx),
        .x25_maint_header(hdr), .irq(irq));

    // ==========================================
    // helpers
    task automatic finish_test();
        if (err_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following call never reassigns psel in the same step
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd_check(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        check(q, exp);
    endtask

    // s: 0 dev init, 1 bus init, 2 tx err, 3 rx err, 4 selftest fault, 5 diag fault
    task automatic pulse(input int s, input int n);
        repeat (n) begin
            {diag_fault, selftest_fault, rx_error, tx_error, bus_init, dev_init} <= 6'h01 << s;
            @(posedge pclk);
            {diag_fault, selftest_fault, rx_error, tx_error, bus_init, dev_init} <= 6'h00;
            @(posedge pclk);
        end
    endtask

    task automatic wait_ccr();
        int n;
        n = 0;
        while (ccr !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
    endtask

    // ==========================================
    // scenarios
    task automatic t_boot();
        logic [1:0] top;
        check(ccr, 1'b0);
        check(led, 8'h40);
        wait_ccr();
        check(ccr, 1'b1);
        repeat (3) @(posedge pclk);
        check(led[5:0], 6'h00);
        top = led[7:6];
        repeat (ROT) @(posedge pclk);
        check(led[7:6], 2'(~top));
    endtask

    task automatic t_counts();
        pulse(2, 9);
        pulse(3, 3);
        repeat (3) @(posedge pclk);
        check(led[5:0], 6'h0B);
        rd_check(mds_pkg::OFS_COUNTS, 32'h13);
        pulse(0, 1);
        check(ccr, 1'b0);
        rd_check(mds_pkg::OFS_COUNTS, 32'h0);
        wait_ccr();
    endtask

    task automatic t_fault();
        logic [31:0] q;
        logic        e;
        pulse(1, 1);
        selftest_code <= 3'h5;
        pulse(4, 1);
        repeat (3) @(posedge pclk);
        check(tx_enable, 1'b0);
        check(led[2:0], 3'h5);
        repeat (20) @(posedge pclk);
        check(ccr, 1'b0);
        rd_check(mds_pkg::OFS_STATUS, 32'h00014502);
        apb(1'b0, mds_pkg::OFS_INT_STATUS, 32'h0, q, e);
        check(q[0], 1'b1);
        check(irq, 1'b0);
        wr(mds_pkg::OFS_INT_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        check(irq, 1'b1);
        wr(mds_pkg::OFS_INT_STATUS, 32'h1F);
        repeat (2) @(posedge pclk);
        check(irq, 1'b0);
        // an unmapped word must be refused, not aliased
        apb(1'b0, 12'h040, 32'h0, q, e);
        check(e, 1'b1);
        check(q, 32'h0);
        rd_check(mds_pkg::OFS_CTRL, 32'h2);
        // soft initialisation leaves the halt like any other init
        wr(mds_pkg::OFS_CTRL, 32'h3);
        wait_ccr();
        check(ccr, 1'b1);
    endtask

    task automatic t_stand();
        set_test <= 1'b1;
        repeat (2) @(posedge pclk);
        check(diag_active, 1'b1);
        check(ccr, 1'b0);
        set_pack <= 4'h9;
        repeat (40) @(posedge pclk);
        check(subtest, 3'h4);
        check(led[7:3], 5'h14);
        set_pack <= 4'hF;
        repeat (40) @(posedge pclk);
        check(subtest, 3'h7);
        check({x25_maint_tx, hdr}, {1'b1, mds_pkg::X25_MAINT_HEADER});
        diag_code <= 3'h3;
        pulse(5, 1);
        repeat (2) @(posedge pclk);
        check(led[2:0], 3'h3);
        set_test <= 1'b0;
        set_pack <= 4'h0;
        repeat (2) @(posedge pclk);
        check({diag_active, ccr}, 2'h0);
        wait_ccr();
    endtask

    task automatic t_host();
        set_loopback <= 1'b1;
        set_test <= 1'b1;
        pulse(0, 1);
        repeat (2) @(posedge pclk);
        check(hostbus_active, 1'b0);
        set_test <= 1'b0;
        pulse(0, 1);
        repeat (2) @(posedge pclk);
        check({hostbus_active, ccr, led[7:6]}, 4'hB);
        set_test <= 1'b1;
        repeat (2) @(posedge pclk);
        check({diag_active, hostbus_active}, 2'h2);
        set_test <= 1'b0;
        set_loopback <= 1'b0;
        wait_ccr();
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        t_boot();
        t_counts();
        t_fault();
        t_stand();
        t_host();
        finish_test();
    end
endmodule
